// ==== bench/sbgt_pin_src.sv ====
// Model of the count pin and gate pin sources outside the timer.
`timescale 1ns/1ps
module sbgt_pin_src (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [15:0] num,
	input  wire logic        gate_lvl,
	output logic             external_count_pin,
	output logic             gate_pin,
	output logic             busy
);
	logic [15:0] left;

	// Each edge is high one cycle, then low one cycle, so the pin idles low.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left <= 16'h0000;
			external_count_pin <= 1'b0;
		end else if (go) begin
			left <= num;
		end else if (left != 16'h0000) begin
			external_count_pin <= ~external_count_pin;
			if (external_count_pin)
				left <= left - 16'h0001;
		end
	end

	// The gate is a plain level chosen by the bench.
	assign gate_pin = gate_lvl;
	assign busy     = (left != 16'h0000);
endmodule

// ==== bench/sbgt_top_tb.sv ====
// Self-checking bench for the sixteen-bit general timer.
`timescale 1ns/1ps
module sbgt_top_tb;
	import sbgt_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq, pin, gate, busy, go = 1'b0;
	logic idle_mode = 1'b0, gate_lvl = 1'b0;
	logic [31:0] hrdata;
	logic [15:0] num = 16'h0000, c1;
	int bad_count = 0, total_checks = 0, cyc = 0;
	logic [31:0] rows [4][2] = '{'{32'hFFFFFFFF, 32'hA076},
		'{32'h00005F89, 32'h0}, '{32'h76, 32'h76}, '{32'h2000, 32'h2000}};
	logic [15:0] ps [4][2] = '{'{16'h5, 16'h5}, '{16'h10, 16'h2},
		'{16'h80, 16'h2}, '{16'h100, 16'h1}};

	sbgt_top sbgt_top_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .external_count_pin(pin),
		.gate_pin(gate), .idle_mode(idle_mode), .irq(irq));
	sbgt_pin_src sbgt_pin_src_inst (.clk(clk), .rst_n(rst_n), .go(go),
		.num(num), .gate_lvl(gate_lvl), .external_count_pin(pin),
		.gate_pin(gate), .busy(busy));

	// The clock toggles every half period of 10 ns.
	always #10 clk = ~clk;

	// A hang is cut short well beyond the expected run length.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_irq(input logic exp);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	// One single transfer; the address phase holds until hready is high.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	// Sends n rising edges from the pin model and lets them settle.
	task automatic pulses(input logic [15:0] n);
		@(posedge clk);
		num <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy) @(posedge clk);
		repeat (20) @(posedge clk);
	endtask

	// Stops, loads the count and starts again with a new control value.
	task automatic restart(input logic [31:0] ctrl);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_COUNT, 32'h0);
		wr(OFF_CTRL, ctrl);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rdc(OFF_CTRL + 8'(i * 4));
			chk(rd, 32'h0);
		end
		chk_irq(1'b0);
		chk({31'h0, hresp}, 32'h0);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL, rows[i][0]);
			rdc(OFF_CTRL);
			chk(rd, rows[i][1]);
		end
		wr(8'h10, 32'h1234);
		rdc(8'h10);
		chk(rd, 32'h0);
		$display("control rows done");
		for (int i = 0; i < 4; i++) begin
			restart(32'h8002 | (32'(i) << 4));
			pulses(ps[i][0]);
			rdc(OFF_COUNT);
			chk(rd, {16'h0, ps[i][1]});
		end
		restart(32'h8042);
		pulses(16'h4);
		rdc(OFF_COUNT);
		chk(rd, 32'h4);
		restart(32'h8006);
		pulses(16'h3);
		rdc(OFF_COUNT);
		chk(rd, 32'h3);
		wr(OFF_COUNT, 32'h1234);
		rdc(OFF_COUNT);
		chk(rd, 32'h3);
		$display("external counting done");
		restart(32'h8000);
		repeat (30) @(posedge clk);
		wr(OFF_CTRL, 32'h0);
		rdc(OFF_COUNT);
		c1 = rd[15:0];
		repeat (10) @(posedge clk);
		rdc(OFF_COUNT);
		chk(rd, {16'h0, c1});
		chk({31'h0, c1 > 16'h10}, 32'h1);
		restart(32'h8040);
		repeat (20) @(posedge clk);
		rdc(OFF_COUNT);
		chk(rd, 32'h0);
		gate_lvl <= 1'b1;
		repeat (20) @(posedge clk);
		rdc(OFF_COUNT);
		chk({31'h0, rd[15:0] > 16'h10}, 32'h1);
		gate_lvl <= 1'b0;
		rdc(OFF_STATUS);
		chk(rd & 32'h2, 32'h2);
		idle_mode <= 1'b1;
		restart(32'hA000);
		repeat (20) @(posedge clk);
		rdc(OFF_COUNT);
		chk(rd, 32'h0);
		wr(OFF_CTRL, 32'h8000);
		repeat (20) @(posedge clk);
		rdc(OFF_COUNT);
		chk({31'h0, rd[15:0] > 16'h10}, 32'h1);
		idle_mode <= 1'b0;
		$display("internal modes done");
		wr(OFF_CTRL, 32'h0);
		wr(OFF_STATUS, 32'h3);
		wr(OFF_COUNT, 32'hFFFF);
		wr(OFF_MASK, 32'h1);
		wr(OFF_CTRL, 32'h8002);
		pulses(16'h1);
		rdc(OFF_COUNT);
		chk(rd, 32'h0);
		chk_irq(1'b1);
		wr(OFF_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk_irq(1'b0);
		wr(OFF_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk_irq(1'b1);
		wr(OFF_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk_irq(1'b0);
		rdc(OFF_STATUS);
		chk(rd & 32'h1, 32'h0);
		$display("interrupt done");
		wr(OFF_CTRL, 32'h8000);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(OFF_CTRL);
		chk(rd, 32'h0);
		rdc(OFF_COUNT);
		chk(rd, 32'h0);
		chk_irq(1'b0);
		$display("mid-run reset done");
		summarize();
	end
endmodule

// ==== common/sbgt_pkg.sv ====
// Constants, register map and mode codes for the sixteen-bit general timer.
// Behaviour
// RL1: Sixteen-bit counter, interval timer or event counter.
// RL2: Timer modes count the internal instruction clock.
// RL3: Counter modes count external pin rising edges.
// RL4: Mode chosen by bits 1, 2, 6.
// RL5: Synchronise prescaler output, else count asynchronously.
// RL6: Bit 15 runs or halts the counter.
// RL7: Bit 13 stops counting while in Idle.
// RL8: Bit 6 gates internal clock; ignored externally.
// RL9: Bits 5-4 select 1:1, 1:8, 1:64, 1:256.
// RL10: Bit 2 synchronises external input; ignored internally.
// RL11: Bit 1 selects external pin or internal clock.
// RL12: Synchronous counter running ignores count writes.
// RL13: Unused control bits read zero, ignore writes.
// RL14: Gated mode counts only while gate high.
package sbgt_pkg;

	// Bus decode width and register byte offsets.
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_COUNT  = 8'h04;
	localparam logic [7:0]  OFF_STATUS = 8'h08;
	localparam logic [7:0]  OFF_MASK   = 8'h0C;

	// Control field positions.
	localparam int unsigned RUN_BIT  = 15;
	localparam int unsigned IDLE_BIT = 13;
	localparam int unsigned GATE_BIT = 6;
	localparam int unsigned PS_HI    = 5;
	localparam int unsigned PS_LO    = 4;
	localparam int unsigned SYNC_BIT = 2;
	localparam int unsigned CS_BIT   = 1;

	// Writable control bits; everything else reads as zero.
	localparam logic [15:0] CTRL_MASK  = 16'hA076;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] COUNT_RST  = 16'h0000;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

	// Status and mask layout.
	localparam int unsigned STAT_W   = 2;
	localparam int unsigned ST_OVF   = 0;
	localparam int unsigned ST_GATE  = 1;
	localparam logic [1:0]  STAT_RST = 2'h0;
	localparam logic [1:0]  MASK_RST = 2'h0;

	// Prescaler terminal counts for each ratio code.
	localparam logic [7:0] PS_LAST_1   = 8'h00;
	localparam logic [7:0] PS_LAST_8   = 8'h07;
	localparam logic [7:0] PS_LAST_64  = 8'h3F;
	localparam logic [7:0] PS_LAST_256 = 8'hFF;

	// AHB transfer type with a transfer present.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// Operating modes, one-hot.
	typedef enum logic [3:0] {
		MODE_TIMER = 4'b0001,
		MODE_GATED = 4'b0010,
		MODE_SYNC  = 4'b0100,
		MODE_ASYNC = 4'b1000
	} sbgt_mode_e;

	// Terminal count of the prescaler for a ratio code.
	function automatic logic [7:0] ps_last(input logic [1:0] sel);
		unique case (sel)
			2'h0: ps_last = PS_LAST_1;
			2'h1: ps_last = PS_LAST_8;
			2'h2: ps_last = PS_LAST_64;
			2'h3: ps_last = PS_LAST_256;
		endcase
	endfunction

endpackage

// ==== rtl/sbgt_prescaler.sv ====
// Input clock prescaler for the general timer.
`timescale 1ns/1ps
module sbgt_prescaler (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       tick_in,
	input  wire logic [1:0] ratio_sel,
	output logic            tick_out
);
	import sbgt_pkg::*;

	logic [7:0] cnt;
	wire  [7:0] last    = ps_last(ratio_sel);
	wire        at_last = (cnt == last);

	// Count input ticks and emit one pulse per full ratio.
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			cnt      <= 8'h00;
			tick_out <= 1'b0;
		end else begin
			tick_out <= tick_in && at_last; // see RL9
			if (tick_in) begin
				cnt <= at_last ? 8'h00 : cnt + 8'h01;
			end
		end
	end

	// A pulse out follows the ratio-th input tick exactly.
	presc_ratio_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL9
		tick_out |-> ($past(tick_in) && !$past(clear) && $past(at_last)))
		else $error("prescaler pulse without terminal count");

endmodule

// ==== rtl/sbgt_sync.sv ====
// Pulse synchroniser that carries prescaled pin ticks into the device clock.
`timescale 1ns/1ps
module sbgt_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pulse_in,
	output logic      pulse_out
);
	import sbgt_pkg::*;

	logic tog;
	logic s1;
	logic s2;
	logic s3;

	// Toggle on each pulse, then three flops; only s2 reads s1.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tog <= 1'b0;
			s1  <= 1'b0;
			s2  <= 1'b0;
			s3  <= 1'b0;
		end else begin
			tog <= tog ^ pulse_in;
			s1  <= tog;
			s2  <= s1;
			s3  <= s2;
		end
	end

	// Edge of the synchronised toggle marks one delivered pulse.
	assign pulse_out = s2 ^ s3; // see RL5

	// A pulse reaches the far side three cycles later.
	sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL5
		pulse_in |-> ##3 pulse_out)
		else $error("synchronised pulse late or lost");

endmodule

// ==== rtl/sbgt_top.sv ====
// Sixteen-bit general timer with AHB-Lite registers and an interrupt.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module sbgt_top #(
	parameter int unsigned INSTR_DIV = 1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        external_count_pin,
	input  wire logic        gate_pin,
	input  wire logic        idle_mode,
	output logic             irq
);
	import sbgt_pkg::*;

	localparam logic [7:0] DIV_LAST = 8'(INSTR_DIV - 1);

	// Register state.
	logic [15:0]       timer_one_control;
	logic [15:0]       count_value;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] mask;

	// Bus state between address and data phase.
	logic [ADDR_W-1:0] addr_q;
	logic              wr_pend;
	logic              rd_pend;

	// Clocking and edge state.
	logic [7:0] div_cnt;
	logic       pin_q;
	logic       gate_q;

	// Address decode shared by write and read paths.
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Control fields.
	wire       run_control            = timer_one_control[RUN_BIT];
	wire       idle_stop              = timer_one_control[IDLE_BIT];
	wire       gate_accumulate_enable = timer_one_control[GATE_BIT];
	wire [1:0] prescale_select        = timer_one_control[PS_HI:PS_LO];
	wire       ext_input_synchronise  = timer_one_control[SYNC_BIT];
	wire       clock_source_select    = timer_one_control[CS_BIT];

	// Mode from source, sync and gate bits; unused bits drop out.
	sbgt_mode_e mode;
	assign mode = clock_source_select ? // see RL4
		(ext_input_synchronise ? MODE_SYNC : MODE_ASYNC) : // see RL10
		(gate_accumulate_enable ? MODE_GATED : MODE_TIMER); // see RL8

	// Bus request decode; only NONSEQ and SEQ carry a transfer.
	wire bus_take = hsel && hready && htrans[1];
	wire wr_take  = bus_take && hwrite;
	wire rd_take  = bus_take && !hwrite;

	// Data-phase write strobes per register.
	wire wr_ctrl   = wr_pend && hit(addr_q, OFF_CTRL);
	wire wr_cntraw = wr_pend && hit(addr_q, OFF_COUNT);
	wire wr_stat   = wr_pend && hit(addr_q, OFF_STATUS);
	wire wr_mask   = wr_pend && hit(addr_q, OFF_MASK);

	// A running synchronous counter refuses software loads.
	wire wr_block = clock_source_select && ext_input_synchronise
		&& run_control;
	wire wr_count = wr_cntraw && !wr_block; // see RL12

	// Counting is halted when off, or when idle with stop-in-idle set.
	wire run = run_control && !(idle_mode && idle_stop); // see RL6 RL7

	// Instruction clock enable from a divider of the device clock.
	wire icy_tick = (div_cnt == DIV_LAST); // see RL2

	// Rising edge of the pin and falling edge of the gate.
	wire pin_rise  = external_count_pin && !pin_q; // see RL3 RL11
	wire gate_fall = gate_q && !gate_pin;

	// Prescaler input per mode; gated mode passes ticks only with gate.
	logic presc_in;
	always_comb begin
		presc_in = 1'b0;
		unique case (mode)
			MODE_TIMER: presc_in = icy_tick; // see RL2
			MODE_GATED: presc_in = icy_tick && gate_pin; // see RL14
			MODE_SYNC:  presc_in = pin_rise; // see RL3
			MODE_ASYNC: presc_in = pin_rise; // see RL3
		endcase
	end

	wire ps_tick;
	wire sy_tick;

	// Prescaler restarts whenever the timer is switched off.
	sbgt_prescaler u_presc (
		.clk       (clk),
		.rst_n     (rst_n),
		.clear     (!run_control),
		.tick_in   (presc_in && run),
		.ratio_sel (prescale_select),
		.tick_out  (ps_tick)
	);

	// Synchronisation happens after the prescaler, not on the raw pin.
	sbgt_sync u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pulse_in  (ps_tick),
		.pulse_out (sy_tick)
	);

	// Synchronous mode uses the resynchronised tick; the others do not.
	// Ticks still in the synchroniser when run drops are discarded.
	wire count_tick = run && ((mode == MODE_SYNC) ? sy_tick : ps_tick); // see RL5

	// Events: counter wrap and end of a gated accumulation.
	wire ev_ovf  = count_tick && (count_value == COUNT_MAX) && !wr_count;
	wire ev_gate = (mode == MODE_GATED) && run && gate_fall;
	wire [STAT_W-1:0] stat_set = {ev_gate, ev_ovf};
	wire [STAT_W-1:0] stat_clr = wr_stat ? hwdata[STAT_W-1:0] : '0;

	// Next values; a hardware set wins over a same-cycle clear.
	wire [15:0]       load_val    = hwdata[15:0];
	wire [STAT_W-1:0] next_status = (status & ~stat_clr) | stat_set;
	wire [15:0] next_count = wr_count ? load_val :
		(count_tick ? count_value + 16'h0001 : count_value); // see RL1
	wire [15:0] next_ctrl = wr_ctrl ? (load_val & CTRL_MASK) :
		timer_one_control; // see RL13

	// Interrupt source; registered below so the pin comes from a flop.
	wire irq_src = |(status & mask);

	// Read data mux; unmapped offsets read as zero.
	wire [31:0] rd_mux =
		hit(addr_q, OFF_CTRL)   ? {16'h0000, timer_one_control} :
		hit(addr_q, OFF_COUNT)  ? {16'h0000, count_value} :
		hit(addr_q, OFF_STATUS) ? {{(32-STAT_W){1'b0}}, status} :
		hit(addr_q, OFF_MASK)   ? {{(32-STAT_W){1'b0}}, mask} :
		32'h00000000;

	// Bus phase tracking. Reads take one wait state so that a read
	// right after a write sees the written value.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_q    <= '0;
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend <= wr_take;
			rd_pend <= rd_take;
			hresp   <= 1'b0;
			if (bus_take) begin
				addr_q <= haddr[ADDR_W-1:0];
			end
			hreadyout <= !rd_take;
		end
	end

	// Read data is loaded in the wait cycle and holds until the next read.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (rd_pend) begin
			hrdata <= rd_mux;
		end
	end

	// Control and mask registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			timer_one_control <= CTRL_RST;
			mask              <= MASK_RST;
		end else begin
			timer_one_control <= next_ctrl;
			if (wr_mask) begin
				mask <= hwdata[STAT_W-1:0];
			end
		end
	end

	// Counter, status and interrupt.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_value <= COUNT_RST;
			status      <= STAT_RST;
			irq         <= 1'b0;
		end else begin
			count_value <= next_count;
			status      <= next_status;
			irq         <= irq_src;
		end
	end

	// Instruction clock divider and edge history.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt <= 8'h00;
			pin_q   <= 1'b0;
			gate_q  <= 1'b0;
		end else begin
			div_cnt <= icy_tick ? 8'h00 : div_cnt + 8'h01;
			pin_q   <= external_count_pin;
			gate_q  <= gate_pin;
		end
	end

	// Reserved control bits never hold a one.
	ctrl_reserved_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL13
		(timer_one_control & ~CTRL_MASK) == 16'h0000)
		else $error("reserved control bit set");

	// Switched off, the count holds unless software loads it.
	halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL6
		(!run_control && !wr_count) |=> $stable(count_value))
		else $error("count moved while halted");

	// Idle with stop-in-idle freezes the count.
	idle_freeze_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL7
		(idle_mode && idle_stop && !wr_count) |=> $stable(count_value))
		else $error("count moved in idle");

	// A refused load leaves the count as counting made it.
	load_refuse_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL12
		(wr_cntraw && wr_block && !count_tick) |=> $stable(count_value))
		else $error("blocked count write took effect");

	// Each tick adds exactly one, wrapping at sixteen bits.
	count_step_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL1
		(count_tick && !wr_count) |=>
		(count_value == 16'($past(count_value) + 16'h0001)))
		else $error("count did not step by one");

	// Gate low blocks every internal tick in gated mode.
	gate_block_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL14
		(mode == MODE_GATED && !gate_pin) |-> !presc_in)
		else $error("gated tick with gate low");

	// External source follows pin edges and ignores the gate bit.
	ext_source_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL11
		clock_source_select |-> (presc_in == pin_rise))
		else $error("external source not pin edge");

	// Internal source ignores the pin entirely.
	int_source_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL2
		(!clock_source_select && !gate_accumulate_enable)
		|-> (presc_in == icy_tick))
		else $error("internal source wrong");

	// Overflow sets its sticky bit on the next edge.
	ovf_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		ev_ovf |=> status[ST_OVF])
		else $error("overflow flag not set");

	// Interrupt follows unmasked status one cycle later.
	irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> (irq == $past(irq_src)))
		else $error("interrupt level mismatch");

	// A read holds the bus exactly one wait cycle.
	read_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	// Pin clocking with synchronisation selects the synchronous mode.
	mode_sync_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL10
		(clock_source_select && ext_input_synchronise) |->
		(mode == MODE_SYNC))
		else $error("synchronous counter mode not selected");

	// Pin clocking without synchronisation counts asynchronously.
	mode_async_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL4
		(clock_source_select && !ext_input_synchronise) |->
		(mode == MODE_ASYNC))
		else $error("asynchronous counter mode not selected");

	// The gate bit picks gated mode only with the internal clock.
	mode_gated_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL8
		(!clock_source_select && gate_accumulate_enable) |->
		(mode == MODE_GATED))
		else $error("gated timer mode not selected");

	// Synchronous mode counts only what leaves the synchroniser.
	sync_path_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL5
		(mode == MODE_SYNC) |->
		(count_tick == (run && sy_tick)))
		else $error("synchronous count bypassed synchroniser");

	// Asynchronous mode counts the prescaler output directly.
	async_path_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL5
		(mode == MODE_ASYNC) |->
		(count_tick == (run && ps_tick)))
		else $error("asynchronous count path wrong");

	// A gate falling edge in gated mode with run high sets its sticky bit.
	gate_event_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL14
		ev_gate |=> status[ST_GATE])
		else $error("gate event flag not set");

	// An overflow flag stays set until software writes a one to it.
	ovf_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		(status[ST_OVF] && !(wr_stat && hwdata[ST_OVF])) |=> status[ST_OVF])
		else $error("overflow flag lost");

	// An accepted software load replaces the count.
	count_load_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL12
		wr_count |=>
		(count_value == $past(load_val)))
		else $error("count load not applied");

	// A control write keeps only the implemented bits.
	ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL13
		wr_ctrl |=>
		(timer_one_control == ($past(load_val) & CTRL_MASK)))
		else $error("control write not applied");

	// Writes complete with no wait state.
	write_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_take |=> hreadyout)
		else $error("write inserted a wait state");

endmodule
